// file: logic/bfs_chan.v
// one monitor channel: power accumulation and readable result capture
// assumes conversion results arrive already coded in the active format
`timescale 1ns/1ps

module bfs_chan #(
  parameter ACC_W = 48
) (
  input  wire               core_clk,
  input  wire               rst_n,
  input  wire               conv_valid,
  input  wire [15:0]        shunt_raw,
  input  wire [15:0]        rail_raw,
  input  wire               cur_signed,
  input  wire               volt_signed,
  input  wire               snap,
  input  wire               clear_acc,
  output reg  [15:0]        snap_shunt,
  output reg  [15:0]        snap_rail,
  output reg  [ACC_W-1:0]   snap_acc,
  output reg                snap_cur_signed,
  output reg                snap_volt_signed,
  output reg                snap_pwr_signed
);

  //////////////////////////////////////////////////////////////////////////
  // operand extension: sign bit only counts when the format is signed
  wire signed [16:0] shunt_ext;
  wire signed [16:0] rail_ext;
  wire signed [33:0] power;
  wire [ACC_W-1:0]   power_ext;
  reg  [ACC_W-1:0]   acc;
  reg  [15:0]        last_shunt;
  reg  [15:0]        last_rail;

  assign shunt_ext = {cur_signed & shunt_raw[15], shunt_raw};
  assign rail_ext  = {volt_signed & rail_raw[15], rail_raw};
  // product is signed whenever either direction bit is set
  assign power     = shunt_ext * rail_ext;
  assign power_ext = {{(ACC_W-34){power[33]}}, power};

  //////////////////////////////////////////////////////////////////////////
  // internal accumulator and latest results
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc        <= {ACC_W{1'b0}};
      last_shunt <= 16'h0000;
      last_rail  <= 16'h0000;
    end else begin
      if (clear_acc) begin
        acc <= {ACC_W{1'b0}};
      end else if (conv_valid) begin
        acc <= acc + power_ext;
      end
      if (conv_valid) begin
        last_shunt <= shunt_raw;
        last_rail  <= rail_raw;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // readable copies, held until the next snapshot of any kind
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_shunt       <= 16'h0000;
      snap_rail        <= 16'h0000;
      snap_acc         <= {ACC_W{1'b0}};
      snap_cur_signed  <= 1'b0;
      snap_volt_signed <= 1'b0;
      snap_pwr_signed  <= 1'b0;
    end else if (snap) begin
      snap_shunt       <= last_shunt;
      snap_rail        <= last_rail;
      snap_acc         <= acc;
      snap_cur_signed  <= cur_signed;
      snap_volt_signed <= volt_signed;
      snap_pwr_signed  <= cur_signed | volt_signed;
    end
  end

endmodule

// file: logic/bfs_defs.vh
// register offsets, command codes, reset values and timing counts
// for the channel format and snapshot block; definitions only
`ifndef BFS_DEFS_VH
`define BFS_DEFS_VH

// register and command codes on the serial register port
`define BFS_ADDR_POLARITY_FMT  8'h1d
`define BFS_CMD_SNAPSHOT       8'h00
`define BFS_CMD_SNAPSHOT_BCAST 8'h1e
`define BFS_CMD_SNAPSHOT_KEEP  8'h1f

// reset value of the format register
`define BFS_POLARITY_FMT_RST   8'h00

// field positions in the format register
`define BFS_CUR_SIGNED_HI      7
`define BFS_CUR_SIGNED_LO      4
`define BFS_VOLT_SIGNED_HI     3
`define BFS_VOLT_SIGNED_LO     0

// settle time before results may be read, and its cycle count at 40 MHz
`define BFS_CLK_HZ             40000000
`define BFS_SETTLE_US          1000
`define BFS_SETTLE_CYCLES      ((`BFS_SETTLE_US * (`BFS_CLK_HZ / 1000)) / 1000)

`endif

// file: logic/bfs_top.v
// channel format register and snapshot command decode for a
// four-channel power monitor; one serial register port, one clock
// assumes the serial front end hands over whole bytes as strobes
//
// How it works
// - current bit selects unsigned or signed sense
// - voltage bit selects unsigned or signed rail
// - either bit makes power results signed
// - code 1Eh send-byte alone triggers snapshot
// - broadcast snapshot equals ordinary accumulate-restart snapshot
// - snapshot copies totals, count, latest results
// - restart snapshot (00h, 1Eh) then clears accumulators and counter; 1Fh keeps them
// - results valid one millisecond after command
// - readable results held until next snapshot
`timescale 1ns/1ps
`include "bfs_defs.vh"

module bfs_top #(
  parameter ACC_W         = 48,
  parameter CNT_W         = 24,
  parameter SETTLE_CYCLES = `BFS_SETTLE_CYCLES
) (
  input  wire               core_clk,
  input  wire               rst_n,
  input  wire               cmd_send,
  input  wire [7:0]         cmd_code,
  input  wire               reg_wr,
  input  wire [7:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  output reg  [7:0]         reg_rdata,
  input  wire [3:0]         conv_valid,
  input  wire [63:0]        shunt_voltage,
  input  wire [63:0]        rail_voltage,
  output wire [3:0]         conv_cur_signed,
  output wire [3:0]         conv_volt_signed,
  output wire [63:0]        snap_shunt_voltage,
  output wire [63:0]        snap_rail_voltage,
  output wire [4*ACC_W-1:0] snap_acc,
  output reg  [CNT_W-1:0]   snap_count,
  output wire [3:0]         snap_cur_signed,
  output wire [3:0]         snap_volt_signed,
  output wire [3:0]         snap_pwr_signed,
  output wire               snap_busy,
  output reg                snap_done
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]  channel_polarity_format;
  reg  [7:0]  active_format;
  reg  [CNT_W-1:0] acc_count;
  reg  [31:0] settle_cnt;
  wire        snap_restart;
  wire        snap_keep;
  wire        snap_any;
  wire        any_conv;

  //////////////////////////////////////////////////////////////////////////
  // command decode: a send-byte with no data carries only its code;
  // the broadcast code behaves exactly like the ordinary restart code
  assign snap_restart = cmd_send &
                        ((cmd_code == `BFS_CMD_SNAPSHOT) |
                         (cmd_code == `BFS_CMD_SNAPSHOT_BCAST));
  assign snap_keep    = cmd_send & (cmd_code == `BFS_CMD_SNAPSHOT_KEEP);
  assign snap_any     = snap_restart | snap_keep;
  assign any_conv     = |conv_valid;

  //////////////////////////////////////////////////////////////////////////
  // format register write; read back of the programmed value
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_polarity_format <= `BFS_POLARITY_FMT_RST;
    end else if (reg_wr && reg_addr == `BFS_ADDR_POLARITY_FMT) begin
      channel_polarity_format <= reg_wdata;
    end
  end

  // registered read data, unmapped addresses read zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `BFS_ADDR_POLARITY_FMT) begin
      reg_rdata <= channel_polarity_format;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pending format becomes active only on a restart snapshot, so
  // conversions in flight never mix two formats
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_format <= `BFS_POLARITY_FMT_RST;
    end else if (snap_restart) begin
      active_format <= channel_polarity_format;
    end
  end

  assign conv_cur_signed  = active_format[`BFS_CUR_SIGNED_HI:`BFS_CUR_SIGNED_LO];
  assign conv_volt_signed = active_format[`BFS_VOLT_SIGNED_HI:`BFS_VOLT_SIGNED_LO];

  //////////////////////////////////////////////////////////////////////////
  // accumulation counter: one count per conversion round, cleared by a
  // restart snapshot after its value has been copied out
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_count  <= {CNT_W{1'b0}};
      snap_count <= {CNT_W{1'b0}};
    end else begin
      if (snap_any) begin
        snap_count <= acc_count;
      end
      if (snap_restart) begin
        acc_count <= {CNT_W{1'b0}};
      end else if (any_conv && acc_count != {CNT_W{1'b1}}) begin
        acc_count <= acc_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channels: capture uses the format that was active when the data was
  // converted, so the copy is taken before the format switch lands
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      // channel 1 sits in the top bit of each nibble
      bfs_chan #(
        .ACC_W (ACC_W)
      ) u_chan (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .conv_valid       (conv_valid[ch]),
        .shunt_raw        (shunt_voltage[16*ch+15:16*ch]),
        .rail_raw         (rail_voltage[16*ch+15:16*ch]),
        .cur_signed       (conv_cur_signed[3-ch]),
        .volt_signed      (conv_volt_signed[3-ch]),
        .snap             (snap_any),
        .clear_acc        (snap_restart),
        .snap_shunt       (snap_shunt_voltage[16*ch+15:16*ch]),
        .snap_rail        (snap_rail_voltage[16*ch+15:16*ch]),
        .snap_acc         (snap_acc[ACC_W*ch+ACC_W-1:ACC_W*ch]),
        .snap_cur_signed  (snap_cur_signed[3-ch]),
        .snap_volt_signed (snap_volt_signed[3-ch]),
        .snap_pwr_signed  (snap_pwr_signed[3-ch])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // settle window after any snapshot; done pulses when reads are allowed
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 32'h0000_0000;
      snap_done  <= 1'b0;
    end else begin
      snap_done <= 1'b0;
      if (snap_any) begin
        settle_cnt <= SETTLE_CYCLES[31:0];
      end else if (settle_cnt != 32'h0000_0000) begin
        settle_cnt <= settle_cnt - 32'h0000_0001;
        snap_done  <= (settle_cnt == 32'h0000_0001);
      end
    end
  end

  assign snap_busy = (settle_cnt != 32'h0000_0000);

endmodule

// file: test/bfs_master.sv
// serial bus master model: byte writes, reads and send-byte commands
// assumes the bench calls its tasks; signals change just after an edge
`timescale 1ns/1ps
module bfs_master #(
  parameter SETTLE_CYCLES = 8
) (
  input  wire       core_clk,
  output reg        cmd_send,
  output reg  [7:0] cmd_code,
  output reg        reg_wr,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    cmd_send  = 1'b0;
    cmd_code  = 8'hff;
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // one byte written; data line turned over once released
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // one byte read after the registered answer has landed
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      repeat (2) @(posedge core_clk);
      d = reg_rdata;
    end
  endtask
  // send-byte command: code alone, no data byte
  task cmd(input [7:0] c);
    begin
      @(posedge core_clk);
      cmd_send <= 1'b1;
      cmd_code <= c;
      @(posedge core_clk);
      cmd_send <= 1'b0;
      cmd_code <= ~c;
    end
  endtask
  // no read until the settle time has run out
  task settle;
    repeat (SETTLE_CYCLES + 2) @(posedge core_clk);
  endtask
endmodule

// file: test/bfs_props.sv
// port assertions for the channel format and snapshot block
// assumes it is bound into bfs_top and handed its parameters
`timescale 1ns/1ps
module bfs_props #(
  parameter ACC_W         = 48,
  parameter CNT_W         = 24,
  parameter SETTLE_CYCLES = 8
) (
  input wire               core_clk,
  input wire               rst_n,
  input wire               cmd_send,
  input wire [7:0]         cmd_code,
  input wire               reg_wr,
  input wire [7:0]         reg_addr,
  input wire [7:0]         reg_wdata,
  input wire [7:0]         reg_rdata,
  input wire [3:0]         conv_cur_signed,
  input wire [3:0]         conv_volt_signed,
  input wire [63:0]        snap_shunt_voltage,
  input wire [4*ACC_W-1:0] snap_acc,
  input wire [CNT_W-1:0]   snap_count,
  input wire [3:0]         snap_cur_signed,
  input wire [3:0]         snap_pwr_signed,
  input wire               snap_busy,
  input wire               snap_done
);
  reg  [7:0]  fmt;
  reg  [15:0] busy_cnt;
  wire        restart = cmd_send && (cmd_code == 8'h00 || cmd_code == 8'h1e);
  wire        snap    = restart || (cmd_send && cmd_code == 8'h1f);
  ////////////////////////////////////////
  // shadow of the format register and length of the settle window
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt      <= 8'h00;
      busy_cnt <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == 8'h1d) begin
        fmt <= reg_wdata;
      end
      busy_cnt <= snap ? 16'h0000 : busy_cnt + {15'h0000, snap_busy};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_fmt_read;
    (reg_wr && reg_addr == 8'h1d) ##1 (!reg_wr && reg_addr == 8'h1d)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format readback wrong");
  property p_cur_act;
    restart |=> conv_cur_signed == $past(fmt[7:4]);
  endproperty
  a_cur_act: assert property (p_cur_act) else $error("current format not taken");
  property p_volt_act;
    restart |=> conv_volt_signed == $past(fmt[3:0]);
  endproperty
  a_volt_act: assert property (p_volt_act) else $error("rail format not taken");
  property p_fmt_keep;
    !restart |=> $stable(conv_cur_signed) && $stable(conv_volt_signed);
  endproperty
  a_fmt_keep: assert property (p_fmt_keep) else $error("format changed early");
  property p_snap_fmt;
    snap |=> snap_cur_signed == $past(conv_cur_signed);
  endproperty
  a_snap_fmt: assert property (p_snap_fmt) else $error("captured format wrong");
  property p_pwr;
    snap |=> snap_pwr_signed == $past(conv_cur_signed | conv_volt_signed);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power sign flag wrong");
  property p_hold;
    !snap |=> $stable(snap_shunt_voltage) && $stable(snap_acc) && $stable(snap_count);
  endproperty
  a_hold: assert property (p_hold) else $error("results moved without snapshot");
  property p_busy_start;
    (cmd_send && cmd_code == 8'h1e) |=> snap_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("command not taken");
  property p_busy_len;
    $fell(snap_busy) |-> snap_done && busy_cnt == SETTLE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("settle window length wrong");
  c_bcast: cover property (cmd_send && cmd_code == 8'h1e);
  c_keep: cover property (cmd_send && cmd_code == 8'h1f);
  c_done: cover property (snap_done);
endmodule

bind bfs_top bfs_props #(.ACC_W(ACC_W), .CNT_W(CNT_W), .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
  .core_clk, .rst_n, .cmd_send, .cmd_code, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
  .conv_cur_signed, .conv_volt_signed, .snap_shunt_voltage, .snap_acc, .snap_count,
  .snap_cur_signed, .snap_pwr_signed, .snap_busy, .snap_done);

// file: test/tb_bidir_format_and_snapshot.sv
// self-checking bench for the channel format and snapshot block
// assumes a 40 MHz clock and a settle window shortened to 8 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_bidir_format_and_snapshot;
  localparam [39:0] CODES = 40'h1e_1f00_551e;
  reg          core_clk      = 1'b0;
  reg          rst_n         = 1'b0;
  reg  [3:0]   conv_valid    = 4'h0;
  reg  [63:0]  shunt_voltage = 64'h0;
  reg  [63:0]  rail_voltage  = 64'h0;
  wire         cmd_send, reg_wr;
  wire [7:0]   cmd_code, reg_addr, reg_wdata, reg_rdata;
  wire [3:0]   conv_cur_signed, conv_volt_signed;
  wire [63:0]  snap_shunt_voltage, snap_rail_voltage;
  wire [191:0] snap_acc;
  wire [23:0]  snap_count;
  wire [3:0]   snap_cur_signed, snap_volt_signed, snap_pwr_signed;
  integer      errors = 0, cmp_count = 0, seed = 4175, r, k, i;
  reg  [7:0]   fmt, act, code, d, exp_fmt;
  reg  [63:0]  sh, rl, last_sh, last_rl, exp_sh, exp_rl;
  reg  [191:0] acc, exp_acc;
  reg  [23:0]  cnt, exp_cnt;
  longint      a, b;

  bfs_top #(.SETTLE_CYCLES(8)) u_bfs_top (
    .core_clk, .rst_n, .cmd_send, .cmd_code, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .conv_valid, .shunt_voltage, .rail_voltage, .conv_cur_signed, .conv_volt_signed,
    .snap_shunt_voltage, .snap_rail_voltage, .snap_acc, .snap_count, .snap_cur_signed,
    .snap_volt_signed, .snap_pwr_signed, .snap_busy(), .snap_done());
  bfs_master #(.SETTLE_CYCLES(8)) u_bfs_master (
    .core_clk, .cmd_send, .cmd_code, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
  ////////////////////////////////////////
  // clock, verdict and watchdog
  always #12.5 core_clk = ~core_clk;
  task wrap_up;
    begin
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #50000;
    errors++;
    wrap_up;
  end
  ////////////////////////////////////////
  // rounds of format write, conversions and one command each
  initial begin
    {act, exp_fmt, acc, cnt, last_sh, last_rl, exp_sh, exp_rl, exp_acc, exp_cnt} = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    u_bfs_master.rd(8'h1d, d);
    `CHK(d, 8'h00)
    u_bfs_master.rd(8'h20, d);
    `CHK(d, 8'h00)
    for (r = 0; r < 5; r++) begin
      fmt = $random(seed);
      u_bfs_master.wr(8'h1d, fmt);
      u_bfs_master.rd(8'h1d, d);
      `CHK(d, fmt)
      for (k = 0; k < 3; k++) begin
        @(posedge core_clk);
        sh = {$random(seed), $random(seed)};
        rl = {$random(seed), $random(seed)};
        shunt_voltage <= sh;
        rail_voltage  <= rl;
        conv_valid    <= 4'hf;
        for (i = 0; i < 4; i++) begin
          a = act[7-i] ? longint'($signed(sh[16*i +: 16])) : longint'(sh[16*i +: 16]);
          b = act[3-i] ? longint'($signed(rl[16*i +: 16])) : longint'(rl[16*i +: 16]);
          acc[48*i +: 48] = acc[48*i +: 48] + 48'(a * b);
        end
        {last_sh, last_rl, cnt} = {sh, rl, cnt + 24'h1};
      end
      @(posedge core_clk);
      conv_valid    <= 4'h0;
      shunt_voltage <= ~sh;
      code = CODES[8*(4-r) +: 8];
      u_bfs_master.cmd(code);
      if (code != 8'h55) begin
        {exp_sh, exp_rl, exp_acc, exp_cnt} = {last_sh, last_rl, acc, cnt};
        exp_fmt = act;
      end
      if (code == 8'h00 || code == 8'h1e) begin
        {act, acc, cnt} = {fmt, 192'h0, 24'h0};
      end
      u_bfs_master.settle;
      `CHK(snap_shunt_voltage, exp_sh)
      `CHK(snap_rail_voltage, exp_rl)
      `CHK(snap_acc, exp_acc)
      `CHK(snap_count, exp_cnt)
      `CHK({conv_cur_signed, conv_volt_signed}, act)
      `CHK({snap_cur_signed, snap_volt_signed}, exp_fmt)
      `CHK(snap_pwr_signed, exp_fmt[7:4] | exp_fmt[3:0])
    end
    wrap_up;
  end
endmodule
